// ---- rtl/spindle_orient_map.svh ----
/*
  Constants of the spindle orientation positioner: timing, scaling and
  the configuration values held after reset.
  Assumes a 40 MHz mclk and a 4096-pulse-per-turn load shaft encoder.
*/
`ifndef SPINDLE_ORIENT_MAP_SVH
`define SPINDLE_ORIENT_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SOP_CLK_PERIOD_NS    25
`define SOP_MS_NS            1000000
`define SOP_MS_CYCLES        (`SOP_MS_NS / `SOP_CLK_PERIOD_NS)
`define SOP_ACCEL_RPM_PER_S  500
`define SOP_RAMP_MS          (1000 / `SOP_ACCEL_RPM_PER_S)

// ----------------------------------------------------------------------
// Scaling
// ----------------------------------------------------------------------
`define SOP_PULSES_PER_REV   4096
`define SOP_TENTHS_PER_REV   3600
`define SOP_TAU_MIN_MS       10'h005

// ----------------------------------------------------------------------
// Configuration values after reset
// ----------------------------------------------------------------------
`define SOP_DEF_COMP_WIDTH   8'h05
`define SOP_DEF_CANCEL_WIDTH 8'h0A
`define SOP_DEF_ORIENT_SPEED 10'h190
`define SOP_DEF_BCD_STEP     11'h00A
`define SOP_DEF_VSTOP_OFS    7'h00
`define SOP_DEF_CHANGE_RATIO 7'h00
`define SOP_DEF_SOFT_TIME    6'h00
`define SOP_DEF_STOP_BCD     12'h000

`endif

// ---- rtl/spindle_orient_pkg.sv ----
/*
  Types of the spindle orientation positioner.
  Assumes the constants of spindle_orient_map.svh.
*/
package spindle_orient_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SOFT   = 3'b001,
    ST_ORIENT = 3'b011,
    ST_BLEND  = 3'b010,
    ST_SERVO  = 3'b110
  } orient_state_t;

  // Settings frozen while the drive runs
  typedef struct packed {
    logic [7:0]  completion_width;
    logic [7:0]  cancel_width;
    logic [9:0]  orientation_speed;
    logic [10:0] bcd_step_tenths;
    logic [6:0]  virtual_stop_offset;
    logic [6:0]  speed_change_ratio;
    logic [5:0]  soft_start_time;
    logic [11:0] stop_bcd;
  } orient_cfg_t;

  typedef struct packed {
    logic       reverse;
    logic [9:0] rpm;
  } speed_cmd_t;

endpackage : spindle_orient_pkg

// ---- rtl/spindle_orientation_positioner.sv ----
/*
  Spindle orientation positioner: soft start, fixed orientation speed,
  graded hand-over to a position servo, completion flag, integral term.
  Assumes encoder step, direction and origin pulses synchronous to mclk,
  one cycle each, and a speed loop downstream that takes speed_cmd.
*/
// What this block does
// - In orientation with medium or low gear or low winding, the low-range integral time applies.
// - Each millisecond the integral term grows by the proportional term over the time constant.
// - Completion is raised when the shaft is within the completion width of the stop position.
// - Once raised, completion falls only when the shaft leaves the cancel width or orientation ends.
// - After the origin is seen, the fixed orientation speed is held until the servo demand drops below it.
// - Each BCD step of the stop command is a configurable angle in tenths of a degree.
// - The servo target carries a virtual offset that is zeroed once the completion width is met.
// - The hand-over to servo speed steps down by the changing ratio each millisecond.
// - From rest the speed rises at 500 min^-1 per second for at most the soft start time.
// - With all gear and winding selects off, the high-range time constant applies.
`timescale 1ns/10ps
`include "spindle_orient_map.svh"

module spindle_orientation_positioner #(
  parameter int MS_CYCLES = `SOP_MS_CYCLES
) (
  input  wire logic                              mclk,
  input  wire logic                              rstn,
  input  wire logic                              orientation_command,
  input  wire logic                              medium_gear_select,
  input  wire logic                              low_gear_select,
  input  wire logic                              low_winding_select,
  input  wire logic                              drive_stopped,
  input  wire logic                              enc_step,
  input  wire logic                              enc_reverse,
  input  wire logic                              enc_origin,
  input  wire logic signed [15:0]                torque_p,
  input  wire logic [9:0]                        high_range_integral_time,
  input  wire logic [9:0]                        low_range_integral_time,
  input  wire spindle_orient_pkg::orient_cfg_t   cfg_in,
  output spindle_orient_pkg::speed_cmd_t         speed_cmd,
  output logic signed [23:0]                     integral_term,
  output logic                                   positioning_complete,
  output logic                                   low_range_active,
  output spindle_orient_pkg::orient_state_t      orient_state
);

  spindle_orient_pkg::orient_cfg_t   cfg_reg;
  spindle_orient_pkg::orient_state_t state_reg;
  spindle_orient_pkg::speed_cmd_t    speed_reg;
  logic [11:0]        pos_reg;
  logic               origin_seen_reg;
  logic               offset_on_reg;
  logic               complete_reg;
  logic               low_range_reg;
  logic signed [23:0] integ_reg;
  logic [31:0]        ms_cnt_reg;
  logic [3:0]         ramp_cnt_reg;
  logic [5:0]         soft_ms_reg;
  logic               ms_tick;
  logic               ramp_tick;
  logic               active;
  logic               low_sel;
  logic [9:0]         tau_sel;
  logic [9:0]         bcd_val;
  logic [20:0]        tenths;
  logic [32:0]        scaled;
  logic [11:0]        stop_pos;
  logic [11:0]        drive_target;
  logic signed [11:0] err_stop;
  logic signed [11:0] err_drive;
  logic [11:0]        abs_stop;
  logic [11:0]        abs_drive;
  logic [9:0]         servo_rpm;
  logic [7:0]         cancel_eff;
  logic signed [15:0] integ_inc;

  assign active = (state_reg != spindle_orient_pkg::ST_IDLE);

  // ----------------------------------------------------------------------
  // Settings capture
  // ----------------------------------------------------------------------
  // Sample only at rest
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= '{completion_width:    `SOP_DEF_COMP_WIDTH,
                   cancel_width:        `SOP_DEF_CANCEL_WIDTH,
                   orientation_speed:   `SOP_DEF_ORIENT_SPEED,
                   bcd_step_tenths:     `SOP_DEF_BCD_STEP,
                   virtual_stop_offset: `SOP_DEF_VSTOP_OFS,
                   speed_change_ratio:  `SOP_DEF_CHANGE_RATIO,
                   soft_start_time:     `SOP_DEF_SOFT_TIME,
                   stop_bcd:            `SOP_DEF_STOP_BCD};
    end else if (drive_stopped) begin
      cfg_reg <= cfg_in;
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond and ramp ticks
  // ----------------------------------------------------------------------
  assign ms_tick   = (ms_cnt_reg == 32'(MS_CYCLES - 1));
  assign ramp_tick = ms_tick && (ramp_cnt_reg == 4'(`SOP_RAMP_MS - 1));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ms_cnt_reg   <= '0;
      ramp_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 32'h1;
      if (ramp_tick) begin
        ramp_cnt_reg <= '0;
      end else if (ms_tick) begin
        ramp_cnt_reg <= ramp_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shaft position, stop target and errors
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_reg         <= '0;
      origin_seen_reg <= 1'b0;
    end else begin
      if (enc_origin) begin
        pos_reg <= '0;
      end else if (enc_step) begin
        pos_reg <= enc_reverse ? pos_reg - 12'h001 : pos_reg + 12'h001;
      end
      if (!active) begin
        origin_seen_reg <= 1'b0;
      end else if (enc_origin) begin
        origin_seen_reg <= 1'b1;
      end
    end
  end

  // BCD digits times angle per step, then tenths of a degree to pulses
  // Digits widened before the product so that the hundreds and tens cannot wrap
  assign bcd_val  = 10'(cfg_reg.stop_bcd[11:8]) * 10'h064
                  + 10'(cfg_reg.stop_bcd[7:4]) * 10'h00A
                  + 10'(cfg_reg.stop_bcd[3:0]);
  assign tenths   = 21'(bcd_val) * 21'(cfg_reg.bcd_step_tenths);
  assign scaled   = 33'((33'(tenths) * `SOP_PULSES_PER_REV) / `SOP_TENTHS_PER_REV);
  assign stop_pos = scaled[11:0];

  // Virtual offset pulls the servo target past the stop
  assign drive_target = stop_pos + (offset_on_reg ? 12'(cfg_reg.virtual_stop_offset) : 12'h000);
  assign err_stop     = $signed(stop_pos - pos_reg);
  assign err_drive    = $signed(drive_target - pos_reg);
  assign abs_stop     = err_stop[11] ? 12'(-err_stop) : 12'(err_stop);
  assign abs_drive    = err_drive[11] ? 12'(-err_drive) : 12'(err_drive);
  // Gain is applied downstream; demand is the error capped at orientation speed
  assign servo_rpm    = (abs_drive > 12'(cfg_reg.orientation_speed))
                      ? cfg_reg.orientation_speed : abs_drive[9:0];
  // Cancel width never below completion width
  assign cancel_eff   = (cfg_reg.cancel_width < cfg_reg.completion_width)
                      ? cfg_reg.completion_width : cfg_reg.cancel_width;

  // ----------------------------------------------------------------------
  // Sequence and speed reference
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= spindle_orient_pkg::ST_IDLE;
      speed_reg   <= '0;
      soft_ms_reg <= '0;
    end else if (!orientation_command) begin
      state_reg   <= spindle_orient_pkg::ST_IDLE;
      speed_reg   <= '0;
      soft_ms_reg <= '0;
    end else begin
      case (state_reg)
        spindle_orient_pkg::ST_IDLE: begin
          state_reg   <= spindle_orient_pkg::ST_SOFT;
          soft_ms_reg <= '0;
        end
        // Rise one min^-1 per ramp tick until time or speed is reached
        spindle_orient_pkg::ST_SOFT: begin
          if (soft_ms_reg >= cfg_reg.soft_start_time ||
              speed_reg.rpm >= cfg_reg.orientation_speed) begin
            speed_reg.rpm <= cfg_reg.orientation_speed;
            state_reg     <= spindle_orient_pkg::ST_ORIENT;
          end else begin
            if (ramp_tick) begin
              speed_reg.rpm <= speed_reg.rpm + 10'h001;
            end
            if (ms_tick) begin
              soft_ms_reg <= soft_ms_reg + 6'h01;
            end
          end
          speed_reg.reverse <= 1'b0;
        end
        // Fixed speed until the servo demand drops below it
        spindle_orient_pkg::ST_ORIENT: begin
          speed_reg <= '{reverse: 1'b0, rpm: cfg_reg.orientation_speed};
          if (origin_seen_reg && abs_drive < 12'(cfg_reg.orientation_speed)) begin
            state_reg <= spindle_orient_pkg::ST_BLEND;
          end
        end
        // Step down by the ratio each millisecond
        spindle_orient_pkg::ST_BLEND: begin
          speed_reg.reverse <= err_drive[11];
          if (cfg_reg.speed_change_ratio == 7'h00 ||
              speed_reg.rpm <= servo_rpm + 10'(cfg_reg.speed_change_ratio)) begin
            speed_reg.rpm <= servo_rpm;
            state_reg     <= spindle_orient_pkg::ST_SERVO;
          end else if (ms_tick) begin
            speed_reg.rpm <= speed_reg.rpm - 10'(cfg_reg.speed_change_ratio);
          end
        end
        spindle_orient_pkg::ST_SERVO: begin
          speed_reg <= '{reverse: err_drive[11], rpm: servo_rpm};
        end
        default: begin
          state_reg <= spindle_orient_pkg::ST_IDLE;
          speed_reg <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Virtual offset and completion
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      offset_on_reg <= 1'b0;
    end else if (!active) begin
      offset_on_reg <= 1'b1;
    end else if (origin_seen_reg && abs_stop <= 12'(cfg_reg.completion_width)) begin
      offset_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      complete_reg <= 1'b0;
    end else if (!active || !origin_seen_reg) begin
      complete_reg <= 1'b0;
    end else if (!complete_reg) begin
      complete_reg <= (abs_stop <= 12'(cfg_reg.completion_width));
    end else begin
      complete_reg <= (abs_stop <= 12'(cancel_eff));
    end
  end

  // ----------------------------------------------------------------------
  // Integral time selection and accumulation
  // ----------------------------------------------------------------------
  // Any gear or winding select picks the low range
  assign low_sel   = medium_gear_select || low_gear_select || low_winding_select;
  // Low range only during orientation; floor guards the divider
  assign tau_sel   = (orientation_command && low_sel)
                   ? ((low_range_integral_time < `SOP_TAU_MIN_MS)
                      ? `SOP_TAU_MIN_MS : low_range_integral_time)
                   : ((high_range_integral_time < `SOP_TAU_MIN_MS)
                      ? `SOP_TAU_MIN_MS : high_range_integral_time);
  assign integ_inc = 16'(torque_p / $signed({1'b0, tau_sel}));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      integ_reg     <= '0;
      low_range_reg <= 1'b0;
    end else begin
      low_range_reg <= orientation_command && low_sel;
      if (!active) begin
        integ_reg <= '0;
      end else if (ms_tick) begin
        // One millisecond of proportional term over tau
        integ_reg <= integ_reg + 24'(integ_inc);
      end
    end
  end

  assign speed_cmd            = speed_reg;
  assign integral_term        = integ_reg;
  assign positioning_complete = complete_reg;
  assign low_range_active     = low_range_reg;
  assign orient_state         = state_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_low_range_select: assert property ((orientation_command && low_sel) |=> low_range_active)
    else $error("low range not selected");
  a_high_range_select: assert property (!low_sel |=> !low_range_active)
    else $error("high range not selected");
  a_integ_step: assert property ((active && ms_tick && orientation_command)
      |=> integral_term == $past(integ_reg) + 24'($past(integ_inc)))
    else $error("integral step wrong");
  a_complete_set: assert property ((active && origin_seen_reg && orientation_command
      && abs_stop <= 12'(cfg_reg.completion_width)) |=> positioning_complete)
    else $error("completion not raised");
  a_complete_hold: assert property ((positioning_complete && orientation_command
      && abs_stop <= 12'(cancel_eff)) |=> positioning_complete)
    else $error("completion dropped inside cancel width");
  sequence s_orient_held;
    orient_state == spindle_orient_pkg::ST_ORIENT ##1
    orient_state == spindle_orient_pkg::ST_ORIENT;
  endsequence
  a_orient_speed: assert property (s_orient_held |-> speed_cmd.rpm == cfg_reg.orientation_speed)
    else $error("orientation speed not held");
  a_offset_clear: assert property ((active && origin_seen_reg
      && abs_stop <= 12'(cfg_reg.completion_width)) |=> !offset_on_reg)
    else $error("virtual offset not cleared");
  a_blend_down: assert property ((orient_state == spindle_orient_pkg::ST_BLEND
      && orientation_command) |=> speed_cmd.rpm <= $past(speed_reg.rpm))
    else $error("blend speed rose");
  a_soft_bound: assert property (orient_state == spindle_orient_pkg::ST_SOFT
      |-> speed_cmd.rpm <= cfg_reg.orientation_speed)
    else $error("soft start overshoot");
  a_cfg_frozen: assert property (!drive_stopped |=> $stable(cfg_reg))
    else $error("settings changed while running");

endmodule : spindle_orientation_positioner

// ---- dv/spindle_encoder_model.sv ----
/*
  Load shaft encoder model: step and origin pulses of one cycle each, direction held as set with each step.
  Assumes the bench calls its tasks and that mclk is the positioner's clock.
*/
`timescale 1ns/10ps

module spindle_encoder_model (
  input  wire logic mclk,
  output logic      enc_step,
  output logic      enc_reverse,
  output logic      enc_origin
);
  initial begin
    enc_step    = 1'b0;
    enc_reverse = 1'b0;
    enc_origin  = 1'b0;
  end

  // Gap cycle between steps keeps each pulse a single clean count
  task automatic move(input int n, input logic rev);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      enc_step    <= 1'b1;
      enc_reverse <= rev;
      @(posedge mclk);
      enc_step    <= 1'b0;
    end
  endtask : move

  task automatic mark_origin;
    @(posedge mclk);
    enc_origin <= 1'b1;
    @(posedge mclk);
    enc_origin <= 1'b0;
  endtask : mark_origin
endmodule : spindle_encoder_model

// ---- dv/spindle_orientation_positioner_tb.sv ----
/*
  Self-checking bench of the spindle orientation positioner.
  Assumes a shortened millisecond (MS cycles) and the encoder model beside it.
*/
`timescale 1ns/10ps
`include "spindle_orient_map.svh"

module spindle_orientation_positioner_tb;
  localparam int MS = 20;
  logic                              mclk = 1'b0;
  logic                              rstn = 1'b0;
  logic                              orientation_command = 1'b0;
  logic                              medium_gear_select = 1'b0;
  logic                              low_gear_select = 1'b0;
  logic                              low_winding_select = 1'b0;
  logic                              drive_stopped = 1'b1;
  logic                              enc_step;
  logic                              enc_reverse;
  logic                              enc_origin;
  logic signed [15:0]                torque_p = 16'sh03E8;
  logic [9:0]                        high_range_integral_time = 10'h064;
  logic [9:0]                        low_range_integral_time = 10'h032;
  spindle_orient_pkg::orient_cfg_t   cfg_in = '{`SOP_DEF_COMP_WIDTH, `SOP_DEF_CANCEL_WIDTH,
    `SOP_DEF_ORIENT_SPEED, `SOP_DEF_BCD_STEP, `SOP_DEF_VSTOP_OFS, `SOP_DEF_CHANGE_RATIO,
    `SOP_DEF_SOFT_TIME, `SOP_DEF_STOP_BCD};
  spindle_orient_pkg::speed_cmd_t    speed_cmd;
  logic signed [23:0]                integral_term;
  logic                              positioning_complete;
  logic                              low_range_active;
  spindle_orient_pkg::orient_state_t orient_state;
  int                                error_cnt = 0;
  int                                checks_done = 0;

  always #12.5 mclk = ~mclk;

  spindle_orientation_positioner #(.MS_CYCLES(MS)) i_dut (
    .mclk(mclk), .rstn(rstn), .orientation_command(orientation_command),
    .medium_gear_select(medium_gear_select), .low_gear_select(low_gear_select),
    .low_winding_select(low_winding_select), .drive_stopped(drive_stopped),
    .enc_step(enc_step), .enc_reverse(enc_reverse), .enc_origin(enc_origin),
    .torque_p(torque_p), .high_range_integral_time(high_range_integral_time),
    .low_range_integral_time(low_range_integral_time), .cfg_in(cfg_in),
    .speed_cmd(speed_cmd), .integral_term(integral_term),
    .positioning_complete(positioning_complete), .low_range_active(low_range_active),
    .orient_state(orient_state));

  spindle_encoder_model i_enc (
    .mclk(mclk), .enc_step(enc_step), .enc_reverse(enc_reverse), .enc_origin(enc_origin));

  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_state(input spindle_orient_pkg::orient_state_t s, input int lim,
                            output int n);
    n = 0;
    while (orient_state !== s) begin
      @(negedge mclk);
      n++;
      if (n > lim) begin
        check(orient_state, s, "state wait timed out");
        conclude();
      end
    end
  endtask : wait_state

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask : settle

  // Settings only land while the drive is stopped
  task automatic load_cfg;
    @(posedge mclk);
    drive_stopped <= 1'b1;
    repeat (2) @(posedge mclk);
    drive_stopped <= 1'b0;
  endtask : load_cfg

  initial begin
    int                 n;
    int                 tau;
    logic signed [23:0] a;
    repeat (10) @(posedge mclk);
    settle(1);
    check({speed_cmd, positioning_complete, orient_state}, 32'h0, "reset outputs");
    @(posedge mclk);
    rstn <= 1'b1;
    load_cfg();
    // ----------------------------------------------------------------
    // Gear and winding range, integral growth
    // ----------------------------------------------------------------
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      {medium_gear_select, low_gear_select, low_winding_select} <= s[2:0];
      low_range_integral_time <= (s == 7) ? 10'h002 : 10'h032;
      orientation_command <= 1'b1;
      settle(4);
      check(low_range_active, s != 0, "low range select");
      tau = (s == 0) ? 100 : ((s == 7) ? 5 : 50);
      a = integral_term;
      settle(MS);
      check(integral_term - a, 1000 / tau, "integral per ms");
      @(posedge mclk);
      orientation_command <= 1'b0;
      settle(3);
      check({integral_term, orient_state}, 32'h0, "idle clears");
    end
    // ----------------------------------------------------------------
    // Soft start of 4 ms
    // ----------------------------------------------------------------
    @(posedge mclk);
    {medium_gear_select, low_gear_select, low_winding_select} <= 3'b000;
    cfg_in.soft_start_time <= 6'h04;
    load_cfg();
    @(posedge mclk);
    orientation_command <= 1'b1;
    settle(2);
    check(speed_cmd.rpm < 10'h003, 1, "soft ramp rate");
    wait_state(spindle_orient_pkg::ST_ORIENT, 8 * MS, n);
    check(n >= 3 * MS && n <= 5 * MS + 3, 1, "soft start length");
    settle(2);
    check(speed_cmd, {1'b0, 10'h190}, "orientation speed");
    @(posedge mclk);
    orientation_command <= 1'b0;
    // ----------------------------------------------------------------
    // Stop at 30 degrees: blend, servo, completion hysteresis
    // ----------------------------------------------------------------
    @(posedge mclk);
    cfg_in.soft_start_time <= 6'h00;
    cfg_in.stop_bcd <= 12'h030;
    cfg_in.speed_change_ratio <= 7'h0A;
    cfg_in.virtual_stop_offset <= 7'h04;
    load_cfg();
    // Wider width offered while running must not be taken
    @(posedge mclk);
    cfg_in.completion_width <= 8'h32;
    orientation_command <= 1'b1;
    settle(8);
    check({orient_state, speed_cmd.rpm}, {3'b011, 10'h190}, "orient before origin");
    i_enc.mark_origin();
    wait_state(spindle_orient_pkg::ST_SERVO, 10 * MS, n);
    check(n >= 4 * MS && n <= 6 * MS + 4, 1, "blend down length");
    settle(3);
    check(speed_cmd, {1'b0, 10'h159}, "servo speed to offset target");
    i_enc.move(335, 1'b0);
    settle(3);
    check({positioning_complete, speed_cmd.rpm}, {1'b0, 10'h00A}, "error six");
    i_enc.move(1, 1'b0);
    settle(3);
    check({positioning_complete, speed_cmd.rpm}, {1'b1, 10'h005}, "error five, offset off");
    i_enc.move(5, 1'b1);
    settle(3);
    check(positioning_complete, 1'b1, "error ten held");
    i_enc.move(1, 1'b1);
    settle(3);
    check(positioning_complete, 1'b0, "error eleven drops");
    i_enc.move(5, 1'b0);
    settle(3);
    check(positioning_complete, 1'b0, "error six stays off");
    i_enc.move(1, 1'b0);
    settle(3);
    check(positioning_complete, 1'b1, "error five again");
    @(posedge mclk);
    orientation_command <= 1'b0;
    settle(3);
    check({positioning_complete, speed_cmd, orient_state}, 32'h0, "back to idle");
    conclude();
  end
endmodule : spindle_orientation_positioner_tb
